// File: hdl/ocs_regs.svh
/*
 * Offsets, field positions, reset values and timing counts for the boost
 * regulation and charger status registers.
 * Assumes an 8-bit register port from the device's I2C slave logic.
 */
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH

`define OCS_OFS_BOOST_REG       8'h0A
`define OCS_OFS_STATUS          8'h0B
`define OCS_BOOST_RESET         8'h73
`define OCS_BOOST_VCODE_DEFAULT 4'h7
`define OCS_PFM_OFF_DEFAULT     1'b0
`define OCS_BOOST_ICODE_DEFAULT 3'h3
`define OCS_BOOST_VCODE_MSB     7
`define OCS_BOOST_VCODE_LSB     4
`define OCS_PFM_OFF_BIT         3
`define OCS_BOOST_ICODE_MSB     2
`define OCS_BOOST_ICODE_LSB     0
`define OCS_BOOST_BASE_MV       13'h11C6
`define OCS_BOOST_STEP_MV       13'h0040
`define OCS_TARGET_RESET_MV     13'h1386
`define OCS_LIMIT_RESET_MA      12'h0578
`define OCS_WDT_40S_CODE        2'h1
`define OCS_CLK_HZ              100000000
`define OCS_WDT_40S_S           40
`define OCS_WDT_40S_CYCLES      (64'(`OCS_WDT_40S_S) * 64'(`OCS_CLK_HZ))

`endif

// File: hdl/ocs_pkg.sv
/*
 * Types for the boost regulation and charger status register bank.
 * Assumes nothing beyond the register header.
 */
package ocs_pkg;

  typedef struct packed {
    logic [3:0] boost_voltage_code;
    logic       light_load_pulse_mode_off;
    logic [2:0] boost_current_limit_code;
  } ocs_boost_reg_t;

  typedef struct packed {
    logic [2:0] input_source_type;
    logic [1:0] charge_state;
    logic       power_good_flag;
    logic       reserved_zero;
    logic       system_min_regulation_flag;
  } ocs_status_reg_t;

  typedef enum logic [2:0] {
    OCS_SRC_NONE,
    OCS_SRC_STD_HOST,
    OCS_SRC_CHG_HOST,
    OCS_SRC_DEDICATED,
    OCS_SRC_HIGH_VOLT,
    OCS_SRC_UNKNOWN,
    OCS_SRC_NONSTD,
    OCS_SRC_OTG
  } ocs_source_t;

  typedef enum logic [1:0] {
    OCS_CHG_IDLE,
    OCS_CHG_PRE,
    OCS_CHG_FAST,
    OCS_CHG_DONE
  } ocs_charge_t;

endpackage

// File: hdl/ocs_bank.sv
/*
 * Boost regulation register (RW) and primary charger status register (RO).
 * The boost register holds the boost voltage code, the light-load pulse mode
 * disable bit and the boost current limit code, and drives the decoded
 * target voltage in mV and current limit in mA as registered outputs.
 * The status register samples the charger state every cycle and returns it
 * as one byte; the source field follows the detector or the select pin.
 * Read data is registered: it follows the address one clock later.
 * Assumes a one-cycle write strobe from the I2C slave, which holds the
 * address for one cycle before it takes read data from the register port.
 * Assumes status inputs synchronous to SYS_CLK_IN except the source-select
 * pin, a watchdog expiry pulse from the device's watchdog timer, and a
 * register reset pulse from the register reset control.
 * The watchdog period itself is counted outside this block.
 */
// Overview of operation
// R1: Boost target is 4550 mV plus 64 mV per code, default code 0111.
// R2: Pulse light-load mode bit: zero enables it, one disables it.
// R3: Current limit code 000..111 selects 0.5 to 2.45 A, default 011.
// R4: Detection variant reports eight source types from none to OTG.
// R5: Basic variant reports none, standard or charging host by select pin, or OTG.
// R6: Applied current limit is reported elsewhere, never in the source field.
// R7: Charge state reads idle, pre-charge, fast charge or termination done.
// R8: Power good bit reads one for a good input source.
// R9: Reserved status bit always reads zero.
// R10: System floor bit reads one while battery is below the minimum voltage.
// R11: Watchdog code selects off, 40, 80 or 160 s; host access restarts it.
// R12: Watchdog expiry restores voltage and limit defaults but keeps the PFM bit.
`timescale 1ns/100ps
`include "ocs_regs.svh"

module ocs_bank #(
  parameter bit DETECT_VARIANT = 1'b1
) (
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  RST_N_IN,
  input  wire logic                  REG_RESET_IN,
  input  wire logic                  WDT_EXPIRED_IN,
  input  wire logic [7:0]            REG_ADDR_IN,
  input  wire logic                  REG_WR_IN,
  input  wire logic [7:0]            REG_WDATA_IN,
  output logic      [7:0]            REG_RDATA_OUT,
  input  wire logic [2:0]            DETECTED_SOURCE_IN,
  input  wire logic                  SOURCE_PRESENT_IN,
  input  wire logic                  OTG_ACTIVE_IN,
  input  wire logic                  SOURCE_SELECT_PIN_IN,
  input  wire logic [1:0]            CHARGE_STATE_IN,
  input  wire logic                  POWER_GOOD_IN,
  input  wire logic                  SYSTEM_MIN_REG_IN,
  output logic      [3:0]            BOOST_VOLTAGE_CODE_OUT,
  output logic      [12:0]           BOOST_TARGET_MV_OUT,
  output logic                       LIGHT_LOAD_PULSE_MODE_OFF_OUT,
  output logic      [2:0]            BOOST_CURRENT_LIMIT_CODE_OUT,
  output logic      [11:0]           BOOST_CURRENT_LIMIT_MA_OUT
);

  logic                    rst_s1_nxt;
  logic                    rst_s1_r;
  logic                    rst_n_nxt;
  logic                    rst_n_r;
  logic [2:0]              sel_pin_nxt;
  logic [2:0]              sel_pin_r;
  logic                    sel_stable_r;
  logic                    sel_stable_nxt;
  logic                    boost_wr_hit;
  logic                    rd_boost_hit;
  logic                    rd_status_hit;
  logic [7:0]              rdata_nxt;
  logic [7:0]              rdata_r;
  ocs_pkg::ocs_boost_reg_t boost_r;
  ocs_pkg::ocs_boost_reg_t boost_nxt;
  ocs_pkg::ocs_status_reg_t status_r;
  ocs_pkg::ocs_status_reg_t status_nxt;
  logic [12:0]             target_nxt;
  logic [12:0]             target_r;
  logic [11:0]             lim_ma_nxt;
  logic [11:0]             lim_ma_r;

  // Reset release
  always_comb begin
    rst_s1_nxt = 1'b1;
    rst_n_nxt  = rst_s1_r;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= rst_s1_nxt;
      rst_n_r  <= rst_n_nxt;
    end
  end

  // Source-select pin synchroniser; change taken when stages two and three agree
  always_comb begin
    sel_pin_nxt    = {sel_pin_r[1:0], SOURCE_SELECT_PIN_IN};
    sel_stable_nxt = sel_stable_r;
    if (sel_pin_r[1] == sel_pin_r[2]) begin
      sel_stable_nxt = sel_pin_r[2];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_pin_r    <= 3'h0;
      sel_stable_r <= 1'b0;
    end else begin
      sel_pin_r    <= sel_pin_nxt;
      sel_stable_r <= sel_stable_nxt;
    end
  end

  // Address decode
  always_comb begin
    boost_wr_hit  = 1'b0;
    rd_boost_hit  = 1'b0;
    rd_status_hit = 1'b0;
    if (REG_ADDR_IN == `OCS_OFS_BOOST_REG) begin
      boost_wr_hit = REG_WR_IN;
      rd_boost_hit = 1'b1;
    end else if (REG_ADDR_IN == `OCS_OFS_STATUS) begin
      rd_status_hit = 1'b1;
    end
  end

  // Boost regulation register
  always_comb begin
    boost_nxt = boost_r;
    if (REG_RESET_IN) begin
      boost_nxt = `OCS_BOOST_RESET;                                        // [R12]
    end else if (WDT_EXPIRED_IN) begin
      boost_nxt.boost_voltage_code       = `OCS_BOOST_VCODE_DEFAULT;       // [R12] [R11]
      boost_nxt.boost_current_limit_code = `OCS_BOOST_ICODE_DEFAULT;       // [R12]
    end else if (boost_wr_hit) begin
      boost_nxt = REG_WDATA_IN;
    end
  end

  // Boost target and current limit decode
  always_comb begin
    target_nxt = 13'(`OCS_BOOST_BASE_MV + (`OCS_BOOST_STEP_MV * 13'(boost_nxt.boost_voltage_code))); // [R1]
    case (boost_nxt.boost_current_limit_code)                              // [R3]
      3'h0:    lim_ma_nxt = 12'h01F4;
      3'h1:    lim_ma_nxt = 12'h02EE;
      3'h2:    lim_ma_nxt = 12'h04B0;
      3'h3:    lim_ma_nxt = 12'h0578;
      3'h4:    lim_ma_nxt = 12'h0672;
      3'h5:    lim_ma_nxt = 12'h0753;
      3'h6:    lim_ma_nxt = 12'h0866;
      default: lim_ma_nxt = 12'h0992;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      boost_r  <= `OCS_BOOST_RESET;
      target_r <= `OCS_TARGET_RESET_MV;
      lim_ma_r <= `OCS_LIMIT_RESET_MA;
    end else begin
      boost_r  <= boost_nxt;
      target_r <= target_nxt;
      lim_ma_r <= lim_ma_nxt;
    end
  end

  // Status register capture
  always_comb begin
    status_nxt = '0;
    if (OTG_ACTIVE_IN) begin
      status_nxt.input_source_type = ocs_pkg::OCS_SRC_OTG;                 // [R4] [R5]
    end else if (!SOURCE_PRESENT_IN) begin
      status_nxt.input_source_type = ocs_pkg::OCS_SRC_NONE;
    end else if (DETECT_VARIANT) begin
      status_nxt.input_source_type = DETECTED_SOURCE_IN;                   // [R4] [R6]
    end else if (sel_stable_r) begin
      status_nxt.input_source_type = ocs_pkg::OCS_SRC_STD_HOST;            // [R5]
    end else begin
      status_nxt.input_source_type = ocs_pkg::OCS_SRC_CHG_HOST;            // [R5]
    end
    status_nxt.charge_state               = CHARGE_STATE_IN;               // [R7]
    status_nxt.power_good_flag            = POWER_GOOD_IN;                 // [R8]
    status_nxt.reserved_zero              = 1'b0;                          // [R9]
    status_nxt.system_min_regulation_flag = SYSTEM_MIN_REG_IN;             // [R10]
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Read port, registered
  always_comb begin
    if (rd_boost_hit) begin
      rdata_nxt = boost_r;
    end else if (rd_status_hit) begin
      rdata_nxt = status_r;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Register outputs
  assign REG_RDATA_OUT                 = rdata_r;
  assign BOOST_VOLTAGE_CODE_OUT        = boost_r.boost_voltage_code;
  assign BOOST_TARGET_MV_OUT           = target_r;
  assign LIGHT_LOAD_PULSE_MODE_OFF_OUT = boost_r.light_load_pulse_mode_off; // [R2]
  assign BOOST_CURRENT_LIMIT_CODE_OUT  = boost_r.boost_current_limit_code;
  assign BOOST_CURRENT_LIMIT_MA_OUT    = lim_ma_r;

endmodule

// File: tb/ocs_host_model.sv
/* Host model of the register port; assumes writes taken at the rising edge, read data registered one cycle. */
`timescale 1ns/100ps
module ocs_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // Accesses drive only the register port, never the watchdog expiry
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    repeat (2) @(posedge clk_in);
    v = rdata_in;
  endtask
endmodule

// File: tb/ocs_bank_assertions.sv
/* Checker for the boost bank ports; assumes one clock and reset. */
`timescale 1ns/100ps
module ocs_bank_chk (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        REG_RESET_IN,
  input wire logic        WDT_EXPIRED_IN,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic        REG_WR_IN,
  input wire logic [7:0]  REG_WDATA_IN,
  input wire logic [7:0]  REG_RDATA_OUT,
  input wire logic [3:0]  BOOST_VOLTAGE_CODE_OUT,
  input wire logic [12:0] BOOST_TARGET_MV_OUT,
  input wire logic        LIGHT_LOAD_PULSE_MODE_OFF_OUT,
  input wire logic [2:0]  BOOST_CURRENT_LIMIT_CODE_OUT,
  input wire logic [11:0] BOOST_CURRENT_LIMIT_MA_OUT
);
  localparam logic [11:0] MA_TBL [8] = '{12'h1f4, 12'h2ee, 12'h4b0, 12'h578, 12'h672, 12'h753, 12'h866, 12'h992};
  wire logic [7:0] bst = {BOOST_VOLTAGE_CODE_OUT, LIGHT_LOAD_PULSE_MODE_OFF_OUT, BOOST_CURRENT_LIMIT_CODE_OUT};
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  boost_write_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0a && !REG_RESET_IN && !WDT_EXPIRED_IN
    |=> bst == $past(REG_WDATA_IN)) else $error("boost write lost");
  target_mv_a: assert property (BOOST_TARGET_MV_OUT == 13'h11c6 + 13'h0040 * BOOST_VOLTAGE_CODE_OUT)
    else $error("boost target wrong");
  limit_ma_a: assert property (BOOST_CURRENT_LIMIT_MA_OUT == MA_TBL[BOOST_CURRENT_LIMIT_CODE_OUT])
    else $error("current limit wrong");
  reg_reset_a: assert property (REG_RESET_IN |=> bst == 8'h73) else $error("reset value wrong");
  wdt_keep_a: assert property (WDT_EXPIRED_IN && !REG_RESET_IN |=> bst[7:4] == 4'h7 && bst[2:0] == 3'h3
    && $stable(LIGHT_LOAD_PULSE_MODE_OFF_OUT)) else $error("expiry restore wrong");
  rsvd_zero_a: assert property (REG_ADDR_IN == 8'h0b |=> !REG_RDATA_OUT[1]) else $error("reserved bit set");
  unmapped_zero_a: assert property (REG_ADDR_IN != 8'h0a && REG_ADDR_IN != 8'h0b |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  boost_read_a: assert property (REG_ADDR_IN == 8'h0a |=> REG_RDATA_OUT == $past(bst))
    else $error("boost read wrong");
  cover property (REG_ADDR_IN == 8'h0b ##1 REG_RDATA_OUT[7:5] == 3'h7);
  cover property (REG_RESET_IN);
  cover property (WDT_EXPIRED_IN);
  cover property (REG_WR_IN && REG_ADDR_IN == 8'h0a);
endmodule
bind ocs_bank ocs_bank_chk i_chk (.SYS_CLK_IN, .RST_N_IN, .REG_RESET_IN, .WDT_EXPIRED_IN, .REG_ADDR_IN, .REG_WR_IN,
  .REG_WDATA_IN, .REG_RDATA_OUT, .BOOST_VOLTAGE_CODE_OUT, .BOOST_TARGET_MV_OUT, .LIGHT_LOAD_PULSE_MODE_OFF_OUT,
  .BOOST_CURRENT_LIMIT_CODE_OUT, .BOOST_CURRENT_LIMIT_MA_OUT);

// File: tb/ocs_bank_tb.sv
/* Bench for the boost bank; assumes the host model drives the register port. */
`timescale 1ns/100ps
module ocs_bank_tb;
  logic        clk = 0, rst_n = 0, rrst = 0, wdt = 0, pres = 0, otg = 0, pg = 0, smin = 0, psel = 0, wr, pfm;
  logic [7:0]  addr, wdata, rdata, rdata_b, d;
  logic [2:0]  det = 0, lim;
  logic [1:0]  chg = 0;
  logic [3:0]  code;
  logic [12:0] mv;
  logic [11:0] ma;
  int          err_total = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  ocs_bank i_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_RESET_IN(rrst), .WDT_EXPIRED_IN(wdt), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .DETECTED_SOURCE_IN(det), .SOURCE_PRESENT_IN(pres),
    .OTG_ACTIVE_IN(otg), .SOURCE_SELECT_PIN_IN(psel), .CHARGE_STATE_IN(chg), .POWER_GOOD_IN(pg),
    .SYSTEM_MIN_REG_IN(smin), .BOOST_VOLTAGE_CODE_OUT(code), .BOOST_TARGET_MV_OUT(mv),
    .LIGHT_LOAD_PULSE_MODE_OFF_OUT(pfm), .BOOST_CURRENT_LIMIT_CODE_OUT(lim), .BOOST_CURRENT_LIMIT_MA_OUT(ma));
  ocs_host_model i_host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .wdata_out(wdata));
  ocs_bank #(.DETECT_VARIANT(1'b0)) i_dut_basic (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_RESET_IN(rrst),
    .WDT_EXPIRED_IN(wdt), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata_b),
    .DETECTED_SOURCE_IN(det), .SOURCE_PRESENT_IN(pres), .OTG_ACTIVE_IN(otg), .SOURCE_SELECT_PIN_IN(psel),
    .CHARGE_STATE_IN(chg), .POWER_GOOD_IN(pg), .SYSTEM_MIN_REG_IN(smin), .BOOST_VOLTAGE_CODE_OUT(),
    .BOOST_TARGET_MV_OUT(), .LIGHT_LOAD_PULSE_MODE_OFF_OUT(), .BOOST_CURRENT_LIMIT_CODE_OUT(),
    .BOOST_CURRENT_LIMIT_MA_OUT());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(8'h0a, 8'h73);
    chk(ma, 16'h0578);
    rd_chk(8'h0c, 8'h00);
    for (int i = 0; i < 16; i++) begin
      i_host.wr(8'h0a, 8'(i * 17));
      rd_chk(8'h0a, 8'(i * 17));
      chk(mv, 16'h11c6 + 16'h0040 * 16'(i));
    end
    i_host.wr(8'h0b, 8'h00);
    rd_chk(8'h0a, 8'hff);
    @(posedge clk) wdt <= 1'b1;
    @(posedge clk) wdt <= 1'b0;
    rd_chk(8'h0a, 8'h7b);
    chk({code, pfm, lim}, 16'h007b);
    @(posedge clk) rrst <= 1'b1;
    @(posedge clk) rrst <= 1'b0;
    rd_chk(8'h0a, 8'h73);
    pres <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      det <= 3'(i);
      chg <= 2'(i);
      pg <= i[0];
      smin <= ~i[1];
      rd_chk(8'h0b, {3'(i), 2'(i), i[0], 1'b0, ~i[1]});
    end
    psel <= 1'b1;
    repeat (8) @(posedge clk);
    chk(rdata_b, 16'h003c);
    psel <= 1'b0;
    repeat (8) @(posedge clk);
    chk(rdata_b, 16'h005c);
    otg <= 1'b1;
    det <= 3'h3;
    rd_chk(8'h0b, 8'hfc);
    chk(rdata_b, 16'h00fc);
    finish_test;
  end
endmodule
